// file: shared/sdl_map.svh
// Field positions, codes and counts of the serial DAC load logic
`ifndef SDL_MAP_SVH
`define SDL_MAP_SVH
`define SDL_LAST_BIT 4'hf
`define SDL_FIFO_DEPTH 2'h2
`define SDL_AUTO_POS 16
`define SDL_TYPE_MSB 15
`define SDL_TYPE_LSB 14
`define SDL_ADDR_MSB 13
`define SDL_ADDR_LSB 11
`define SDL_VAL_MSB 9
`define SDL_CTRL_REF_POS 0
`define SDL_CTRL_CLRSEL_POS 1
`define SDL_CHAN_WIDTH 7'h0a
`define SDL_DAC_RESET 10'h200
`define SDL_SUB_RESET 10'h000
`define SDL_DATA_RESET 80'h0
`endif

// file: shared/sdl_pkg.sv
// Types of the serial DAC load logic
package sdl_pkg;
  typedef enum logic [1:0] {
    SDL_WORD_DATA,
    SDL_WORD_CTRL,
    SDL_WORD_SUB,
    SDL_WORD_SPARE
  } sdl_word_kind_t;

  typedef struct packed {
    logic [1:0] sck_sync;
    logic sck_prev;
    logic [1:0] fs_sync;
    logic [1:0] sdi_sync;
    logic [1:0] ld_sync;
    logic ld_prev;
    logic [1:0] pd_sync;
    logic [15:0] shift;
    logic [3:0] bit_cnt;
    logic [1:0][16:0] fifo;
    logic [1:0] fill;
    logic rd_ptr;
    logic wr_ptr;
    logic [79:0] data_regs;
    logic [7:0] ref_sel;
    logic [7:0] clr_sel;
    logic low_power;
    logic word_ready;
  } sdl_core_t;

  typedef struct packed {
    logic [79:0] dac;
    logic [79:0] sub;
    logic clearing;
    logic update;
  } sdl_bank_t;
endpackage

// file: design/sdl_load_ctrl.sv
// Serial word capture, two-entry word buffer and DAC register bank, double-buffered for main codes, written directly for sub codes
`timescale 1ns/10ps
`include "sdl_map.svh"
module sdl_load_ctrl (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_frame_sync_n,
  input wire logic i_serial_clock_in,
  input wire logic i_serial_data_in,
  input wire logic i_load_outputs_n,
  input wire logic i_clear_outputs_n,
  input wire logic i_power_down_n,
  output logic [79:0] o_dac_code,
  output logic [79:0] o_sub_code,
  output logic [7:0] o_external_ref_sel,
  output logic [7:0] o_clear_level_sel,
  output logic o_clearing,
  output logic o_dac_update,
  output logic o_low_power,
  output logic o_word_ready
);
  sdl_pkg::sdl_core_t r_reg;
  sdl_pkg::sdl_core_t r_next;
  sdl_pkg::sdl_bank_t b_reg;
  sdl_pkg::sdl_bank_t b_next;
  logic sck_fall;
  logic ld_fall;
  logic shift_en;
  logic push;
  logic pop;
  logic [16:0] head;
  sdl_pkg::sdl_word_kind_t head_kind;
  logic [2:0] head_chan;
  logic [6:0] head_base;
  logic [9:0] head_val;
  logic upd_all;
  logic sub_wr;
  logic bank_rst_n;

  // Clear shares the bank's asynchronous reset so codes drop without a clock
  assign bank_rst_n = i_resetn & i_clear_outputs_n;

  always_comb
  begin
    r_next = r_reg;
    r_next.sck_sync = {r_reg.sck_sync[0], i_serial_clock_in};
    r_next.fs_sync = {r_reg.fs_sync[0], i_frame_sync_n};
    r_next.sdi_sync = {r_reg.sdi_sync[0], i_serial_data_in};
    r_next.ld_sync = {r_reg.ld_sync[0], i_load_outputs_n};
    r_next.pd_sync = {r_reg.pd_sync[0], i_power_down_n};
    r_next.sck_prev = r_reg.sck_sync[1];
    r_next.ld_prev = r_reg.ld_sync[1];
    sck_fall = r_reg.sck_prev & ~r_reg.sck_sync[1];
    ld_fall = r_reg.ld_prev & ~r_reg.ld_sync[1];
    shift_en = sck_fall & ~r_reg.fs_sync[1];
    // Buffer drains only while powered up, so words queue during power-down
    pop = (r_reg.fill != 2'h0) & r_reg.pd_sync[1];
    push = shift_en & (r_reg.bit_cnt == `SDL_LAST_BIT)
           & ((r_reg.fill != `SDL_FIFO_DEPTH) | pop);
    head = r_reg.fifo[r_reg.rd_ptr];
    head_kind = sdl_pkg::sdl_word_kind_t'(head[`SDL_TYPE_MSB:`SDL_TYPE_LSB]);
    head_chan = head[`SDL_ADDR_MSB:`SDL_ADDR_LSB];
    head_base = 7'({4'h0, head_chan} * `SDL_CHAN_WIDTH);
    head_val = head[`SDL_VAL_MSB:0];
    if (r_reg.fs_sync[1])
    begin
      r_next.bit_cnt = 4'h0;
    end
    else if (shift_en)
    begin
      r_next.shift = {r_reg.shift[14:0], r_reg.sdi_sync[1]};
      r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
    end
    if (push)
    begin
      // Load strobe level at the sixteenth edge travels with the word
      r_next.fifo[r_reg.wr_ptr] = {~r_reg.ld_sync[1], r_reg.shift[14:0],
                                   r_reg.sdi_sync[1]};
      r_next.wr_ptr = ~r_reg.wr_ptr;
    end
    upd_all = ld_fall;
    sub_wr = 1'b0;
    if (pop)
    begin
      r_next.rd_ptr = ~r_reg.rd_ptr;
      case (head_kind)
        sdl_pkg::SDL_WORD_DATA:
        begin
          r_next.data_regs[head_base +: 10] = head_val;
          upd_all = upd_all | head[`SDL_AUTO_POS];
        end
        sdl_pkg::SDL_WORD_CTRL:
        begin
          r_next.ref_sel[head_chan] = head_val[`SDL_CTRL_REF_POS];
          r_next.clr_sel[head_chan] = head_val[`SDL_CTRL_CLRSEL_POS];
        end
        sdl_pkg::SDL_WORD_SUB:
        begin
          sub_wr = 1'b1;
        end
        default:
        begin
          sub_wr = 1'b0;
        end
      endcase
    end
    r_next.fill = 2'(r_reg.fill + {1'b0, push} - {1'b0, pop});
    r_next.word_ready = (r_next.fill != `SDL_FIFO_DEPTH);
    r_next.low_power = ~r_reg.pd_sync[1];
  end

  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      r_reg <= '0;
      r_reg.sck_prev <= 1'b1;
      r_reg.ld_prev <= 1'b1;
      r_reg.fs_sync <= 2'h3;
      r_reg.ld_sync <= 2'h3;
      r_reg.pd_sync <= 2'h3;
      r_reg.sck_sync <= 2'h3;
      r_reg.data_regs <= `SDL_DATA_RESET;
      r_reg.word_ready <= 1'b1;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  always_comb
  begin
    b_next = b_reg;
    b_next.clearing = 1'b0;
    b_next.update = upd_all;
    if (upd_all)
    begin
      b_next.dac = r_next.data_regs;
    end
    if (sub_wr)
    begin
      b_next.sub[head_base +: 10] = head_val;
    end
  end

  // Bank kept apart from the core: clear must not disturb a word in flight
  always_ff @(posedge i_mclk or negedge bank_rst_n)
  begin
    if (!bank_rst_n)
    begin
      b_reg.dac <= {8{`SDL_DAC_RESET}};
      b_reg.sub <= {8{`SDL_SUB_RESET}};
      b_reg.clearing <= 1'b1;
      b_reg.update <= 1'b0;
    end
    else
    begin
      b_reg <= b_next;
    end
  end

  assign o_dac_code = b_reg.dac;
  assign o_sub_code = b_reg.sub;
  assign o_clearing = b_reg.clearing;
  assign o_dac_update = b_reg.update;
  assign o_external_ref_sel = r_reg.ref_sel;
  assign o_clear_level_sel = r_reg.clr_sel;
  assign o_low_power = r_reg.low_power;
  assign o_word_ready = r_reg.word_ready;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_resetn);

  sequence s_last_edge;
    shift_en && r_reg.bit_cnt == `SDL_LAST_BIT && r_reg.fill == 2'h0;
  endsequence
  sequence s_auto_drain;
    ##1 pop ##1 o_dac_update;
  endsequence

  a_frame_idle_count: assert property (r_reg.fs_sync[1] |=> r_reg.bit_cnt == 4'h0)
    else $error("bit count not held while frame idle");
  a_fall_shift_bit: assert property (shift_en |=>
    r_reg.shift[0] == $past(r_reg.sdi_sync[1]))
    else $error("serial bit not shifted on falling edge");
  a_word_sixteen_push: assert property (s_last_edge |=> r_reg.fill == 2'h1)
    else $error("word not buffered on sixteenth edge");
  a_strobe_copy_all: assert property ((ld_fall && i_clear_outputs_n) ##1
    i_clear_outputs_n |-> o_dac_code == $past(r_next.data_regs) && o_dac_update)
    else $error("load strobe did not copy data registers");
  // Clear kills the pulse without a clock, so the check stands aside while it is low
  a_auto_update_word: assert property (disable iff (!i_resetn || !i_clear_outputs_n)
    (s_last_edge and (!r_reg.ld_sync[1] && r_reg.shift[14:13] == 2'h0 && r_reg.pd_sync[1]))
    |-> s_auto_drain)
    else $error("automatic update missing after word");
  a_clear_main_code: assert property (!i_clear_outputs_n && $past(!i_clear_outputs_n)
    |-> o_dac_code == {8{`SDL_DAC_RESET}} && o_clearing)
    else $error("main codes not cleared");
  a_clear_sub_code: assert property (!i_clear_outputs_n && $past(!i_clear_outputs_n)
    |-> o_sub_code == {8{`SDL_SUB_RESET}})
    else $error("sub codes not cleared");
  a_power_down_mode: assert property (!r_reg.pd_sync[1] |=> o_low_power ##1
    (o_low_power || r_reg.pd_sync[1]))
    else $error("low-power mode not entered");
  a_ref_select_write: assert property ((pop && head_kind == sdl_pkg::SDL_WORD_CTRL)
    |=> o_external_ref_sel[$past(head_chan)] == $past(head_val[0]))
    else $error("reference select not stored");
  a_data_dest_write: assert property ((pop && head_kind == sdl_pkg::SDL_WORD_DATA)
    |=> r_reg.data_regs[$past(head_base) +: 10] == $past(head_val))
    else $error("data word not routed to channel");
  a_buffer_ready_flag: assert property ((shift_en && r_reg.bit_cnt == `SDL_LAST_BIT
    && o_word_ready) |=> r_reg.fill != 2'h0)
    else $error("word lost although buffer had room");
endmodule

// file: tb/sdl_host_model.sv
// Host model that frames and shifts 16-bit words into the load logic
`timescale 1ns/10ps
module sdl_host_model (
  input wire logic i_mclk,
  output logic o_frame_sync_n,
  output logic o_serial_clock_in,
  output logic o_serial_data_in
);
  initial
  begin
    o_frame_sync_n = 1'b1;
    o_serial_clock_in = 1'b1;
    o_serial_data_in = 1'b0;
  end
  // Serial clock stands high outside frames; 4 + 4 mclk cycles give 200 ns
  task automatic send(input logic [15:0] word, input int nbits);
    int i;
    @(posedge i_mclk);
    o_frame_sync_n <= 1'b0;
    for (i = 15; i > 15 - nbits; i--)
    begin
      o_serial_clock_in <= 1'b1;
      o_serial_data_in <= word[i];
      repeat (4) @(posedge i_mclk);
      o_serial_clock_in <= 1'b0;
      repeat (4) @(posedge i_mclk);
    end
    o_serial_clock_in <= 1'b1;
    o_frame_sync_n <= 1'b1;
    // No pull on the data line, so it must not keep the last bit
    o_serial_data_in <= ~o_serial_data_in;
  endtask
endmodule

// file: tb/sdl_load_ctrl_tb.sv
// Testbench of the serial DAC load logic
`timescale 1ns/10ps
module sdl_load_ctrl_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ld = 1'b1;
  logic clr = 1'b1;
  logic pd = 1'b1;
  logic fs, sck, sd, clring, upd, lowp, rdy;
  logic [79:0] dac, sub;
  logic [7:0] xref, clrsel;
  int num_errors = 0;
  int n_checks = 0;
  always #12.5 clk = ~clk;
  sdl_host_model host (.i_mclk(clk), .o_frame_sync_n(fs), .o_serial_clock_in(sck),
    .o_serial_data_in(sd));
  sdl_load_ctrl dut (.i_mclk(clk), .i_resetn(rstn), .i_frame_sync_n(fs),
    .i_serial_clock_in(sck), .i_serial_data_in(sd), .i_load_outputs_n(ld),
    .i_clear_outputs_n(clr), .i_power_down_n(pd), .o_dac_code(dac), .o_sub_code(sub),
    .o_external_ref_sel(xref), .o_clear_level_sel(clrsel), .o_clearing(clring),
    .o_dac_update(upd), .o_low_power(lowp), .o_word_ready(rdy));
  task automatic check(input string what, input logic [79:0] seen, input logic [79:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Bounded wait for the one-cycle update pulse
  task automatic wait_upd;
    int i;
    // Callers return on a clock edge; let that edge's outputs settle first
    #1;
    for (i = 0; i < 40 && upd !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
    if (upd !== 1'b1)
    begin
      num_errors++;
      $display("Error update pulse expected 1 seen %b", upd);
      give_verdict;
    end
  endtask
  task automatic t_strobe;
    host.send(16'h1155, 16);
    repeat (6) @(posedge clk);
    #1;
    check("held codes", dac, {8{10'h200}});
    @(posedge clk);
    ld <= 1'b0;
    wait_upd;
    check("strobe load", dac, {{5{10'h000}}, 10'h155, {2{10'h000}}});
    $display("strobe test done");
  endtask
  // Strobe left low, so updates come only from the sixteenth edge
  task automatic t_auto;
    host.send(16'h28ab, 16);
    wait_upd;
    check("auto load", dac[59:50], 10'h0ab);
    host.send(16'hffff, 8);
    repeat (4) @(posedge clk);
    host.send(16'h03c3, 16);
    wait_upd;
    check("after partial", dac[9:0], 10'h3c3);
    @(posedge clk);
    ld <= 1'b1;
    $display("auto test done");
  endtask
  task automatic t_ctrl_clear;
    host.send(16'h5803, 16);
    host.send(16'h887f, 16);
    repeat (4) @(posedge clk);
    ld <= 1'b0;
    wait_upd;
    check("ref select", {72'h0, xref}, 80'h08);
    check("clear select", {72'h0, clrsel}, 80'h08);
    check("sub code", sub[19:10], 10'h07f);
    @(posedge clk);
    ld <= 1'b1;
    clr <= 1'b0;
    #1;
    check("clear main", dac, {8{10'h200}});
    check("clear sub", sub, 80'h0);
    check("clearing", {79'h0, clring}, 80'h1);
    repeat (2) @(posedge clk);
    clr <= 1'b1;
    $display("control and clear test done");
  endtask
  // Power-down stops draining, so two words fill the buffer
  task automatic t_power;
    logic [79:0] want;
    @(posedge clk);
    pd <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    check("low power", {79'h0, lowp}, 80'h1);
    host.send(16'h3111, 16);
    host.send(16'h3a22, 16);
    repeat (4) @(posedge clk);
    #1;
    check("buffer full", {79'h0, rdy}, 80'h0);
    // Third word finds the buffer full and is dropped
    host.send(16'h0123, 16);
    pd <= 1'b1;
    repeat (10) @(posedge clk);
    #1;
    check("buffer drained", {78'h0, rdy, lowp}, 80'h2);
    // Word kind 3 must change nothing
    host.send(16'hc2aa, 16);
    repeat (4) @(posedge clk);
    ld <= 1'b0;
    wait_upd;
    want = {10'h222, 10'h111, 10'h0ab, 20'h0, 10'h155, 10'h0, 10'h3c3};
    check("held words", dac, want);
    check("spare sub", sub, 80'h0);
    check("spare select", {72'h0, clrsel}, 80'h08);
    @(posedge clk);
    ld <= 1'b1;
    $display("power test done");
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check("reset codes", dac, {8{10'h200}});
    check("reset sub", sub, 80'h0);
    check("reset flags", {77'h0, clring, lowp, rdy}, 80'h1);
    t_strobe;
    t_auto;
    t_ctrl_clear;
    t_power;
    give_verdict;
  end
endmodule
